/* core/mcr_params.svh */
// constants of the modem configuration register bank
// =============================================================
// Functional notes
// - cfg-one bit 7 enables payload error coding with interleave; resets to 0
// - cfg-one bits 6:4 pick minimum preamble 2,3,4,6,8,12,16,24 bytes; reset 010
// - cfg-one bits 1:0 hold channel step exponent, reset 10; bits 3:2 read-only
// - channel step mantissa resets to f8; step = fref/2^18*(256+m)*2^e
// - channel frequency = base frequency + channel step * channel index
// - deviation = fref/2^17 * (8 + mantissa) * 2^exponent, exponent in bits 6:4
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH

// =============================================================
// register offsets
`define MCR_ADDR_CFG_ONE 16'hdf0f
`define MCR_ADDR_CFG_ZERO 16'hdf10
`define MCR_ADDR_DEVIATION 16'hdf11
`define MCR_ADDR_STEP_LO 16'hdfe0
`define MCR_ADDR_STEP_HI 16'hdfe1
`define MCR_ADDR_DEV_LO 16'hdfe2
`define MCR_ADDR_DEV_HI 16'hdfe3
`define MCR_ADDR_FREQ_B0 16'hdfe4
`define MCR_ADDR_FREQ_B1 16'hdfe5
`define MCR_ADDR_FREQ_B2 16'hdfe6
`define MCR_ADDR_FREQ_B3 16'hdfe7
`define MCR_ADDR_STATUS 16'hdfe8

// =============================================================
// reset values and writable masks
`define MCR_RST_CFG_ONE 8'h22
`define MCR_RST_CFG_ZERO 8'hf8
`define MCR_RST_DEVIATION 8'h40
`define MCR_MASK_CFG_ONE 8'hf3
`define MCR_MASK_CFG_ZERO 8'hff
`define MCR_MASK_DEVIATION 8'h70

// =============================================================
// field positions
`define MCR_FEC_BIT 7
`define MCR_PRE_MSB 6
`define MCR_PRE_LSB 4
`define MCR_EXP_MSB 1
`define MCR_EXP_LSB 0
`define MCR_DEVE_MSB 6
`define MCR_DEVE_LSB 4
`define MCR_STAT_CONFLICT_BIT 0
`define MCR_STAT_SEEN_BIT 1

// =============================================================
// preamble byte counts per code
`define MCR_PRE_BYTES_0 5'h02
`define MCR_PRE_BYTES_1 5'h03
`define MCR_PRE_BYTES_2 5'h04
`define MCR_PRE_BYTES_3 5'h06
`define MCR_PRE_BYTES_4 5'h08
`define MCR_PRE_BYTES_5 5'h0c
`define MCR_PRE_BYTES_6 5'h10
`define MCR_PRE_BYTES_7 5'h18

// =============================================================
// arithmetic constants
`define MCR_STEP_HIDDEN_ONE 4'h1
`define MCR_DEV_HIDDEN_ONE 1'h1

`endif

/* core/mcr_pkg.sv */
// types shared by the modem configuration register bank
`default_nettype none
package mcr_pkg;

  typedef logic [7:0] mcr_byte_t;

  typedef enum logic [1:0] {
    MCR_LEN_FIXED = 2'b00,
    MCR_LEN_VARIABLE = 2'b01,
    MCR_LEN_INFINITE = 2'b10,
    MCR_LEN_RESERVED = 2'b11
  } mcr_len_mode_t;

endpackage : mcr_pkg
`default_nettype wire

/* core/mcr_preamble_lut.sv */
// preamble code to byte count translation
`timescale 1ns/1ps
`default_nettype none
`include "mcr_params.svh"

module mcr_preamble_lut
  import mcr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // code in, count out
  input wire logic [2:0] code_i,
  output logic [4:0] bytes_o
);

  localparam logic [4:0] TABLE [8] = '{
    `MCR_PRE_BYTES_0, `MCR_PRE_BYTES_1, `MCR_PRE_BYTES_2, `MCR_PRE_BYTES_3,
    `MCR_PRE_BYTES_4, `MCR_PRE_BYTES_5, `MCR_PRE_BYTES_6, `MCR_PRE_BYTES_7
  };

  logic [4:0] next_bytes;

  always_comb begin
    next_bytes = TABLE[code_i];
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bytes_o <= `MCR_PRE_BYTES_2;
    end else begin
      bytes_o <= next_bytes;
    end
  end

endmodule : mcr_preamble_lut
`default_nettype wire

/* core/mcr_freq_calc.sv */
// channel step, deviation and channel frequency arithmetic
`timescale 1ns/1ps
`default_nettype none
`include "mcr_params.svh"

module mcr_freq_calc
  import mcr_pkg::*;
#(
  parameter int BASE_W = 24,
  parameter int CHANNEL_INDEX_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // settings
  input wire logic [7:0] step_mantissa_i,
  input wire logic [1:0] step_exponent_i,
  input wire logic [2:0] dev_mantissa_i,
  input wire logic [2:0] dev_exponent_i,
  input wire logic [BASE_W-1:0] base_freq_i,
  input wire logic [CHANNEL_INDEX_W-1:0] channel_index_i,
  // results, step in fref/2^18, deviation in fref/2^17, frequency in fref/2^18
  output logic [11:0] step_o,
  output logic [10:0] dev_o,
  output logic [BASE_W+2:0] freq_o
);

  if (BASE_W < 8 || CHANNEL_INDEX_W < 1 || CHANNEL_INDEX_W + 12 > BASE_W + 2) begin : g_bad_width
    $error("mcr_freq_calc: unsupported base or channel width");
  end

  logic [11:0] next_step;
  logic [10:0] next_dev;
  logic [BASE_W+2:0] next_freq;

  // second stage uses the registered step, so frequency lags step by one cycle
  always_comb begin
    next_step = {`MCR_STEP_HIDDEN_ONE, step_mantissa_i} << step_exponent_i;
    next_dev = 11'({`MCR_DEV_HIDDEN_ONE, dev_mantissa_i}) << dev_exponent_i;
    next_freq = {1'b0, base_freq_i, 2'b00}
              + (BASE_W+3)'(step_o) * (BASE_W+3)'(channel_index_i);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      step_o <= '0;
      dev_o <= '0;
      freq_o <= '0;
    end else begin
      step_o <= next_step;
      dev_o <= next_dev;
      freq_o <= next_freq;
    end
  end

endmodule : mcr_freq_calc
`default_nettype wire

/* core/mcr_top.sv */
// modem configuration register bank: registers, decode and derived values
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_params.svh"

module mcr_top
  import mcr_pkg::*;
#(
  parameter int BASE_W = 24,
  parameter int CHANNEL_INDEX_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // settings held by neighbouring register banks
  input wire logic [1:0] packet_length_mode_i,
  input wire logic [2:0] deviation_mantissa_i,
  input wire logic [BASE_W-1:0] base_freq_i,
  input wire logic [CHANNEL_INDEX_W-1:0] channel_index_i,
  // fields to the modem
  output logic payload_error_coding_enable_o,
  output logic [2:0] preamble_code_o,
  output logic [4:0] preamble_bytes_o,
  output logic [1:0] channel_step_exponent_o,
  output logic [7:0] channel_step_mantissa_o,
  output logic [2:0] deviation_exponent_o,
  // derived values to the synthesizer
  output logic [11:0] channel_step_o,
  output logic [10:0] deviation_o,
  output logic [BASE_W+2:0] channel_freq_o,
  // misuse indication
  output logic error_coding_conflict_o
);

  if (BASE_W + 3 > 32) begin : g_bad_base
    $error("mcr_top: base frequency too wide for the read-back bytes");
  end

  // =============================================================
  // register storage
  mcr_byte_t cfg_one;
  mcr_byte_t cfg_zero;
  mcr_byte_t deviation_reg;
  logic conflict_seen;
  logic conflict_live;
  mcr_byte_t next_cfg_one;
  mcr_byte_t next_cfg_zero;
  mcr_byte_t next_deviation_reg;
  logic next_conflict_seen;
  logic next_conflict_live;

  // =============================================================
  // access decode
  logic hit_cfg_one;
  logic hit_cfg_zero;
  logic hit_deviation;
  logic hit_status;
  logic wr_cfg_one;
  logic wr_cfg_zero;
  logic wr_deviation;
  logic wr_status;

  always_comb begin
    hit_cfg_one = (addr_i == `MCR_ADDR_CFG_ONE);
    hit_cfg_zero = (addr_i == `MCR_ADDR_CFG_ZERO);
    hit_deviation = (addr_i == `MCR_ADDR_DEVIATION);
    hit_status = (addr_i == `MCR_ADDR_STATUS);
    wr_cfg_one = wr_i && hit_cfg_one;
    wr_cfg_zero = wr_i && hit_cfg_zero;
    wr_deviation = wr_i && hit_deviation;
    wr_status = wr_i && hit_status;
  end

  // =============================================================
  // configuration registers
  // masking keeps spare bits at zero whatever software writes
  always_comb begin
    next_cfg_one = cfg_one;
    next_cfg_zero = cfg_zero;
    next_deviation_reg = deviation_reg;
    if (wr_cfg_one) begin
      next_cfg_one = wdata_i & `MCR_MASK_CFG_ONE;
    end
    if (wr_cfg_zero) begin
      next_cfg_zero = wdata_i & `MCR_MASK_CFG_ZERO;
    end
    if (wr_deviation) begin
      next_deviation_reg = wdata_i & `MCR_MASK_DEVIATION;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_one <= `MCR_RST_CFG_ONE;
      cfg_zero <= `MCR_RST_CFG_ZERO;
      deviation_reg <= `MCR_RST_DEVIATION;
    end else begin
      cfg_one <= next_cfg_one;
      cfg_zero <= next_cfg_zero;
      deviation_reg <= next_deviation_reg;
    end
  end

  // =============================================================
  // field outputs
  always_comb begin
    payload_error_coding_enable_o = cfg_one[`MCR_FEC_BIT];
    preamble_code_o = cfg_one[`MCR_PRE_MSB:`MCR_PRE_LSB];
    channel_step_exponent_o = cfg_one[`MCR_EXP_MSB:`MCR_EXP_LSB];
    channel_step_mantissa_o = cfg_zero;
    deviation_exponent_o = deviation_reg[`MCR_DEVE_MSB:`MCR_DEVE_LSB];
  end

  mcr_preamble_lut u_preamble (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .code_i(cfg_one[`MCR_PRE_MSB:`MCR_PRE_LSB]),
    .bytes_o(preamble_bytes_o)
  );

  mcr_freq_calc #(
    .BASE_W(BASE_W),
    .CHANNEL_INDEX_W(CHANNEL_INDEX_W)
  ) u_calc (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .step_mantissa_i(cfg_zero),
    .step_exponent_i(cfg_one[`MCR_EXP_MSB:`MCR_EXP_LSB]),
    .dev_mantissa_i(deviation_mantissa_i),
    .dev_exponent_i(deviation_reg[`MCR_DEVE_MSB:`MCR_DEVE_LSB]),
    .base_freq_i(base_freq_i),
    .channel_index_i(channel_index_i),
    .step_o(channel_step_o),
    .dev_o(deviation_o),
    .freq_o(channel_freq_o)
  );

  // =============================================================
  // error coding misuse watch
  // the device cannot stop software, it only reports the combination
  always_comb begin
    next_conflict_live = cfg_one[`MCR_FEC_BIT]
                      && (packet_length_mode_i != MCR_LEN_FIXED);
    next_conflict_seen = conflict_seen;
    if (wr_status && wdata_i[`MCR_STAT_SEEN_BIT]) begin
      next_conflict_seen = 1'b0;
    end
    // a new conflict in the clearing cycle is kept
    if (next_conflict_live) begin
      next_conflict_seen = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      conflict_live <= 1'b0;
      conflict_seen <= 1'b0;
    end else begin
      conflict_live <= next_conflict_live;
      conflict_seen <= next_conflict_seen;
    end
  end

  always_comb begin
    error_coding_conflict_o = conflict_live;
  end

  // =============================================================
  // read path
  // data stand only in the cycle after the strobe, zero otherwise
  mcr_byte_t rd_mux;
  mcr_byte_t next_rdata;
  logic [31:0] freq_word;

  always_comb begin
    freq_word = 32'(channel_freq_o);
    rd_mux = 8'h00;
    unique case (addr_i)
      `MCR_ADDR_CFG_ONE: rd_mux = cfg_one;
      `MCR_ADDR_CFG_ZERO: rd_mux = cfg_zero;
      `MCR_ADDR_DEVIATION: rd_mux = deviation_reg;
      `MCR_ADDR_STEP_LO: rd_mux = channel_step_o[7:0];
      `MCR_ADDR_STEP_HI: rd_mux = {4'h0, channel_step_o[11:8]};
      `MCR_ADDR_DEV_LO: rd_mux = deviation_o[7:0];
      `MCR_ADDR_DEV_HI: rd_mux = {5'h00, deviation_o[10:8]};
      `MCR_ADDR_FREQ_B0: rd_mux = freq_word[7:0];
      `MCR_ADDR_FREQ_B1: rd_mux = freq_word[15:8];
      `MCR_ADDR_FREQ_B2: rd_mux = freq_word[23:16];
      `MCR_ADDR_FREQ_B3: rd_mux = freq_word[31:24];
      `MCR_ADDR_STATUS: rd_mux = {6'h00, conflict_seen, conflict_live};
      default: rd_mux = 8'h00;
    endcase
    next_rdata = rd_i ? rd_mux : 8'h00;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule : mcr_top
`default_nettype wire

/* testbench/mcr_top_asserts.sv */
// checker for the modem configuration register bank
`timescale 1ns/1ps
`default_nettype none
module mcr_top_asserts (
  // clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // fields and derived values
  input wire logic [2:0] deviation_mantissa_i,
  input wire logic payload_error_coding_enable_o,
  input wire logic [2:0] preamble_code_o,
  input wire logic [4:0] preamble_bytes_o,
  input wire logic [1:0] channel_step_exponent_o,
  input wire logic [7:0] channel_step_mantissa_o,
  input wire logic [2:0] deviation_exponent_o,
  input wire logic [11:0] channel_step_o,
  input wire logic [10:0] deviation_o
);
  localparam logic [4:0] PRE_TBL [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // =============================================================
  // register writes and reads
  property p_cfg1_wr;
    wr_i && addr_i == 16'hdf0f |=> {payload_error_coding_enable_o, preamble_code_o,
      channel_step_exponent_o} == {$past(wdata_i[7:4]), $past(wdata_i[1:0])};
  endproperty
  a_cfg1_wr: assert property (p_cfg1_wr) else $error("cfg one fields not written");
  property p_man_wr;
    wr_i && addr_i == 16'hdf10 |=> channel_step_mantissa_o == $past(wdata_i);
  endproperty
  a_man_wr: assert property (p_man_wr) else $error("mantissa not written");
  property p_dev_wr;
    wr_i && addr_i == 16'hdf11 |=> deviation_exponent_o == $past(wdata_i[6:4]);
  endproperty
  a_dev_wr: assert property (p_dev_wr) else $error("deviation exponent not written");
  // unused bits must read zero whatever was written into them
  property p_rd_cfg1;
    rd_i && addr_i == 16'hdf0f |=> rdata_o == {payload_error_coding_enable_o,
      preamble_code_o, 2'b00, channel_step_exponent_o};
  endproperty
  a_rd_cfg1: assert property (p_rd_cfg1) else $error("cfg one read wrong");
  property p_rd_dev;
    rd_i && addr_i == 16'hdf11 |=> rdata_o == {1'b0, deviation_exponent_o, 4'h0};
  endproperty
  a_rd_dev: assert property (p_rd_dev) else $error("deviation read wrong");
  // =============================================================
  // derived values lag their sources by one cycle
  property p_pre_map;
    preamble_bytes_o == PRE_TBL[$past(preamble_code_o)];
  endproperty
  a_pre_map: assert property (p_pre_map) else $error("preamble count wrong");
  property p_step;
    !$past(reset_i) |->
      channel_step_o == (12'h100 + $past(channel_step_mantissa_o)) << $past(channel_step_exponent_o);
  endproperty
  a_step: assert property (p_step) else $error("channel step wrong");
  property p_dev;
    !$past(reset_i) |->
      deviation_o == (11'h008 + $past(deviation_mantissa_i)) << $past(deviation_exponent_o);
  endproperty
  a_dev: assert property (p_dev) else $error("deviation wrong");
  c_fec_on: cover property ($rose(payload_error_coding_enable_o));
  c_rd_dev: cover property (rd_i && addr_i == 16'hdf11);
  c_exp_max: cover property (channel_step_exponent_o == 2'h3);
endmodule : mcr_top_asserts
bind mcr_top mcr_top_asserts u_asserts (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .deviation_mantissa_i(deviation_mantissa_i),
  .payload_error_coding_enable_o(payload_error_coding_enable_o),
  .preamble_code_o(preamble_code_o), .preamble_bytes_o(preamble_bytes_o),
  .channel_step_exponent_o(channel_step_exponent_o),
  .channel_step_mantissa_o(channel_step_mantissa_o),
  .deviation_exponent_o(deviation_exponent_o), .channel_step_o(channel_step_o),
  .deviation_o(deviation_o)
);
`default_nettype wire

/* testbench/mcr_top_tb.sv */
// self-checking bench for the modem configuration register bank
`timescale 1ns/1ps
`default_nettype none
module mcr_top_tb;
  localparam logic [4:0] PRE_TBL [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
  logic sys_clk_i, reset_i, wr_i, rd_i, fec, conflict;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata, man;
  logic [1:0] len_mode, exp_f;
  logic [2:0] dev_m, code, dev_e;
  logic [4:0] pre_bytes;
  logic [23:0] base;
  logic [7:0] channel_index;
  logic [11:0] step;
  logic [10:0] dev;
  logic [26:0] freq;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  mcr_top uut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .packet_length_mode_i(len_mode),
    .deviation_mantissa_i(dev_m), .base_freq_i(base), .channel_index_i(channel_index),
    .payload_error_coding_enable_o(fec), .preamble_code_o(code), .preamble_bytes_o(pre_bytes),
    .channel_step_exponent_o(exp_f), .channel_step_mantissa_o(man),
    .deviation_exponent_o(dev_e), .channel_step_o(step), .deviation_o(dev),
    .channel_freq_o(freq), .error_coding_conflict_o(conflict)
  );
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // =============================================================
  // access and compare tasks
  task automatic chk(input string name, input logic [26:0] exp, input logic [26:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk($sformatf("rdata %h", a), {19'h0, e}, {19'h0, rdata});
  endtask : rd
  // step lands one edge after the write, frequency one edge later; three edges cover both with one to spare
  task automatic derived(input logic [2:0] c, input logic [7:0] m, input logic [1:0] e);
    logic [11:0] s;
    s = (12'h100 + m) << e;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("bytes", PRE_TBL[c], pre_bytes);
    chk("step", s, step);
    chk("freq", {base, 2'b00} + s * channel_index, freq);
  endtask : derived
  task automatic conclude;
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      conclude();
    end
  end
  // =============================================================
  // scenarios
  initial begin
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    len_mode = 2'b00;
    dev_m = 3'h5;
    base = 24'h123456;
    channel_index = 8'h07;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(16'hdf0f, 8'h22);
    rd(16'hdf10, 8'hf8);
    rd(16'hdf11, 8'h40);
    derived(3'h2, 8'hf8, 2'h2);
    chk("dev", (11'h008 + dev_m) << 4, dev);
    wr(16'hdf0f, 8'hff);
    rd(16'hdf0f, 8'hf3);
    chk("fec", 27'h1, fec);
    wr(16'hdf11, 8'hff);
    rd(16'hdf11, 8'h70);
    rd(16'h0000, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(16'hdf0f, {1'b0, i[2:0], 2'b00, i[1:0]});
      wr(16'hdf10, 8'(i * 37));
      derived(i[2:0], 8'(i * 37), i[1:0]);
      wr(16'hdf11, {1'b0, i[2:0], 4'h0});
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk("dev", (11'h008 + dev_m) << i[2:0], dev);
    end
    chk("fec", 27'h0, fec);
    // error coding with variable length is only flagged, not blocked
    @(posedge sys_clk_i);
    len_mode <= 2'b01;
    wr(16'hdf0f, 8'h80);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("conflict", 27'h1, conflict);
    rd(16'hdfe8, 8'h03);
    // clearing while the conflict persists must leave the sticky bit set
    wr(16'hdfe8, 8'h02);
    rd(16'hdfe8, 8'h03);
    // step (256+3)<<0, deviation (8+5)<<7, freq base*4 + 259*7
    rd(16'hdfe0, 8'h03);
    rd(16'hdfe1, 8'h01);
    rd(16'hdfe2, 8'h80);
    rd(16'hdfe3, 8'h06);
    rd(16'hdfe4, 8'h6d);
    rd(16'hdfe5, 8'hd8);
    rd(16'hdfe6, 8'h48);
    rd(16'hdfe7, 8'h00);
    @(posedge sys_clk_i);
    len_mode <= 2'b00;
    wr(16'hdfe8, 8'h02);
    rd(16'hdfe8, 8'h00);
    chk("conflict", 27'h0, conflict);
    conclude();
  end
endmodule : mcr_top_tb
`default_nettype wire
